/* File: sfr_pkg.sv */
// Package for the supply fault response block: register layout and timing
package sfr_pkg;

	// Policy word command code and field positions
	localparam logic [7:0]  POLICY_CMD       = 8'h23;
	localparam int          RETRY_NUM_LSB    = 0;
	localparam int          ACTION_LSB       = 3;
	localparam int          DELAY_LSB        = 5;
	localparam int          FREEZE_BIT       = 8;
	localparam int          MASK_BIT         = 9;
	localparam int          LINE_STATE_BIT   = 10;
	localparam int          RETRY_CNT_LSB    = 11;
	// Reset value: discharge-gated retry, zero retries, short delay
	localparam logic [15:0] POLICY_RESET     = 16'h0008;
	// Bits that software may write (15:14 reserved, 13:10 read only)
	localparam logic [15:0] POLICY_WR_MASK   = 16'h03ff;
	localparam logic [2:0]  RETRY_UNLIMITED  = 3'h7;
	localparam int          NUM_SUPPLIES     = 6;

	// Clock rate and retry delays in microseconds
	localparam int          CLK_MHZ          = 200;
	localparam longint      DLY_US_0         = 50;
	localparam longint      DLY_US_1         = 200000;
	localparam longint      DLY_US_2         = 410000;
	localparam longint      DLY_US_3         = 820000;
	localparam longint      DLY_US_4         = 1640000;
	localparam longint      DLY_US_5         = 3280000;
	localparam longint      DLY_US_6         = 6550000;
	localparam longint      DLY_US_7         = 13100000;
	// Shared timing line is dead after this many microseconds with no edge
	localparam longint      TIMING_LOSS_US   = 100;
	localparam int          TIMING_LOSS_CYC  = int'(TIMING_LOSS_US * CLK_MHZ);

	// Response action codes
	typedef enum logic [1:0] {
		SFR_ACT_CONTINUE  = 2'h0,
		SFR_ACT_DISCHARGE = 2'h1,
		SFR_ACT_DELAY     = 2'h2,
		SFR_ACT_BOTH      = 2'h3
	} sfr_action_e;

	// Fault sources from the rest of the sequencer
	typedef struct packed {
		logic seq;
		logic sup;
		logic ctl;
	} sfr_faults_s;

	// Register access strobe group
	typedef struct packed {
		logic        wr;
		logic [7:0]  cmd;
		logic [15:0] data;
	} sfr_wr_s;

endpackage : sfr_pkg

/* File: sfr_fault_response.sv */
// Fault response policy logic of a six-channel supply sequencer
// Contract
// R1: Any fault pulls shared fault line low
// R2: External pull-down or dead timing line: other fault
// R3: Mask bit clear ignores external pull-downs
// R4: Responded external pull-down drops all enables
// R5: Freeze halts sequencing, keeps enables on
// R6: Discharge retry waits for all supplies low
// R7: Delay retry waits for delay, ignores voltages
// R8: Delay code maps 50us up to 13.1s
// R9: Combined retry needs discharge and delay
// R10: Continue keeps running, line still pulled
// R11: Retries limited to programmed number
// R12: Read-only counter reports attempted retries
// R13: Counter clears on every new sequence-up
// R14: Status-clear command also clears counter
// R15: Read-only bit shows fault line level
// R16: Action field: continue, discharge, delay, both
// R17: Retry number 0..6, code 7 unlimited
// R18: At limit, fault leaves supplies off
// R19: Delay starts after shutdown; count per retry
`timescale 1ns/1ps
module sfr_fault_response
	import sfr_pkg::*;
#(
	parameter longint DLY_SCALE_DIV = 1
) (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    sys_rst_i,
	// Register access
	input  wire sfr_wr_s                 reg_wr_i,
	input  wire logic                    status_clear_i,
	output logic [15:0]                  policy_rd_o,
	// Sequencer side
	input  wire sfr_faults_s             fault_i,
	input  wire logic                    seq_up_start_i,
	input  wire logic                    seq_enable_i,
	input  wire logic [NUM_SUPPLIES-1:0] seq_en_i,
	input  wire logic [NUM_SUPPLIES-1:0] discharged_i,
	output logic                         retry_start_o,
	output logic                         seq_halt_o,
	// Pins
	input  wire logic                    fault_line_i,
	output logic                         fault_line_o,
	output logic                         fault_line_oe_o,
	input  wire logic                    shared_timing_line_i,
	output logic [NUM_SUPPLIES-1:0]      supply_enable_out_o
);

	typedef enum logic [3:0] {
		ST_RUN    = 4'b0001,
		ST_FROZEN = 4'b0010,
		ST_WAIT   = 4'b0100,
		ST_LOCKED = 4'b1000
	} sfr_state_e;

	// Retry delay decode in cycles; every code shrinks under DLY_SCALE_DIV
	function automatic logic [31:0] delay_cycles(input logic [2:0] code);
		longint us;
		unique case (code)
			3'h0: us = DLY_US_0;
			3'h1: us = DLY_US_1;
			3'h2: us = DLY_US_2;
			3'h3: us = DLY_US_3;
			3'h4: us = DLY_US_4;
			3'h5: us = DLY_US_5;
			3'h6: us = DLY_US_6;
			3'h7: us = DLY_US_7;
		endcase
		return 32'((us * CLK_MHZ) / DLY_SCALE_DIV + 1); // see R8
	endfunction : delay_cycles

	// Pin synchronisers: stage one is read only by stage two
	logic line_s1_q, line_s2_q, tim_s1_q, tim_s2_q, tim_s3_q;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_s1_q <= 1'b1;
			line_s2_q <= 1'b1;
			tim_s1_q  <= 1'b0;
			tim_s2_q  <= 1'b0;
			tim_s3_q  <= 1'b0;
		end else begin
			line_s1_q <= fault_line_i;
			line_s2_q <= line_s1_q;
			tim_s1_q  <= shared_timing_line_i;
			tim_s2_q  <= tim_s1_q;
			tim_s3_q  <= tim_s2_q; // Previous level for edge detect
		end
	end
	logic line_lvl, tim_lvl;
	assign line_lvl = line_s2_q;
	assign tim_lvl  = tim_s2_q;

	// Policy word, watchdog, state, counters
	logic [9:0]             pol_q, pol_d;
	logic [2:0]             cnt_q, cnt_d;
	logic [31:0]            dly_q, dly_d;
	logic [31:0]            wd_q, wd_d;
	logic                   drive_q, drive_d;
	logic [1:0]             drv_h_q, drv_h_d;
	logic                   retry_q, retry_d;
	sfr_state_e             st_q, st_d;
	sfr_action_e            act;
	logic                   int_fault, ext_fault, tim_dead, any_fault;
	logic                   lim_hit, dis_ok, dly_ok, go;

	assign act = sfr_action_e'(pol_q[ACTION_LSB +: 2]); // see R16
	// Own pull-down reaches line_lvl two cycles late through the synchroniser,
	// so drive history masks it; a pull that starts while we drive is missed
	assign ext_fault = pol_q[MASK_BIT] && !line_lvl && !drv_h_q[1]; // see R3
	assign tim_dead  = (wd_q >= 32'(TIMING_LOSS_CYC)); // see R2
	assign int_fault = fault_i.seq | fault_i.sup | fault_i.ctl;
	assign any_fault = int_fault | ext_fault | tim_dead; // see R2
	assign lim_hit   = (pol_q[RETRY_NUM_LSB +: 3] != RETRY_UNLIMITED) &&
		(cnt_q >= pol_q[RETRY_NUM_LSB +: 3]); // see R11 R17
	assign dis_ok    = &discharged_i;
	assign dly_ok    = (dly_q == 32'h0);
	always_comb begin
		unique case (act)
			SFR_ACT_DISCHARGE: go = dis_ok; // see R6
			SFR_ACT_DELAY:     go = dly_ok; // see R7
			SFR_ACT_BOTH:      go = dis_ok && dly_ok; // see R9
			default:           go = 1'b0;
		endcase
	end

	// Next-state logic for the whole policy engine
	always_comb begin
		pol_d   = pol_q;
		cnt_d   = cnt_q;
		dly_d   = (dly_q != 32'h0) ? dly_q - 32'h1 : dly_q;
		wd_d    = (tim_lvl != tim_s3_q) ? 32'h0 :
			(tim_dead ? wd_q : wd_q + 32'h1);
		st_d    = st_q;
		retry_d = 1'b0;
		drive_d = any_fault; // see R1 R10
		drv_h_d = {drv_h_q[0], drive_q};
		if (reg_wr_i.wr && reg_wr_i.cmd == POLICY_CMD)
			pol_d = reg_wr_i.data[9:0];
		unique case (st_q)
			ST_RUN: begin
				if (any_fault && !seq_up_start_i) begin
					if (pol_q[FREEZE_BIT])
						st_d = ST_FROZEN; // see R5
					else if (act != SFR_ACT_CONTINUE) begin // see R10
						// Enables drop next cycle, on the same edge that loads the delay
						st_d  = lim_hit ? ST_LOCKED : ST_WAIT; // see R4 R18
						dly_d = delay_cycles(pol_q[DELAY_LSB +: 3]); // see R19
					end
				end
			end
			ST_WAIT: begin
				if (go) begin
					st_d    = ST_RUN;
					retry_d = 1'b1;
					cnt_d   = cnt_q + 3'h1; // see R12 R19
				end
			end
			ST_FROZEN, ST_LOCKED: begin
			end
		endcase
		// A new sequence-up releases a halted engine
		if (seq_up_start_i) begin
			st_d  = ST_RUN;
			cnt_d = 3'h0; // see R13
		end
		if (status_clear_i)
			cnt_d = 3'h0; // see R14
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pol_q   <= POLICY_RESET[9:0];
			cnt_q   <= 3'h0;
			dly_q   <= 32'h0;
			wd_q    <= 32'h0;
			st_q    <= ST_RUN;
			retry_q <= 1'b0;
			drive_q <= 1'b0;
			drv_h_q <= 2'h0;
		end else begin
			pol_q   <= pol_d;
			cnt_q   <= cnt_d;
			dly_q   <= dly_d;
			wd_q    <= wd_d;
			st_q    <= st_d;
			retry_q <= retry_d;
			drive_q <= drive_d;
			drv_h_q <= drv_h_d;
		end
	end

	// Outputs: enables held on while frozen, forced low while shut down
	logic [NUM_SUPPLIES-1:0] frz_en_q;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			frz_en_q <= '0;
		else if (st_q == ST_RUN)
			frz_en_q <= supply_enable_out_o; // Only outputs truly on stay on
	end
	always_comb begin
		unique case (st_q)
			ST_FROZEN: supply_enable_out_o = frz_en_q; // see R5
			ST_RUN:    supply_enable_out_o = seq_en_i & {NUM_SUPPLIES{seq_enable_i}};
			default:   supply_enable_out_o = '0; // see R4
		endcase
	end
	assign seq_halt_o      = (st_q != ST_RUN);
	assign retry_start_o   = retry_q;
	assign fault_line_o    = 1'b0;
	assign fault_line_oe_o = drive_q; // see R1
	assign policy_rd_o     = {2'h0, cnt_q, line_lvl, pol_q}; // see R12 R15

	// Checks share the one clock; reset quiets them
	default clocking chk_cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_fault_pulls: assert property (int_fault |=> fault_line_oe_o) // see R1
		else $error("fault line not pulled");
	a_mask_ignore: assert property ( // see R3
		(st_q == ST_RUN && !pol_q[MASK_BIT] && !int_fault && !tim_dead
		&& !seq_up_start_i) |=> st_q == ST_RUN)
		else $error("masked pull acted");
	a_freeze_hold: assert property ( // see R5
		(st_q == ST_FROZEN && $past(st_q) == ST_FROZEN) |->
		$stable(supply_enable_out_o)) else $error("frozen enables moved");
	a_shut_low: assert property ( // see R4
		(st_q == ST_RUN && any_fault && !pol_q[FREEZE_BIT] && !seq_up_start_i
		&& act != SFR_ACT_CONTINUE) |=> supply_enable_out_o == '0)
		else $error("enables not dropped");
	a_dis_gate: assert property ( // see R6
		(retry_d && act == SFR_ACT_DISCHARGE) |-> dis_ok)
		else $error("retry before discharge");
	a_dly_gate: assert property ( // see R7
		(retry_d && act[1]) |-> dly_q == 32'h0) else $error("retry early");
	a_cont_run: assert property ( // see R10
		(st_q == ST_RUN && act == SFR_ACT_CONTINUE && !pol_q[FREEZE_BIT]
		&& pol_d[ACTION_LSB +: 2] == 2'h0) |=> st_q == ST_RUN)
		else $error("continue shut down");
	// A fault once the limit is reached must lock the supplies off
	a_limit_hold: assert property ( // see R11 R18
		(st_q == ST_RUN && any_fault && lim_hit && !pol_q[FREEZE_BIT]
		&& !seq_up_start_i && act != SFR_ACT_CONTINUE) |=> st_q == ST_LOCKED)
		else $error("retry past limit");
	// Clear and start win over the increment, so they are left out
	a_retry_count: assert property ( // see R12 R19
		(retry_q && !$past(seq_up_start_i) && !$past(status_clear_i)) |->
		cnt_q == $past(cnt_q) + 3'h1) else $error("retry not counted");
	a_cnt_clear: assert property ( // see R13 R14
		(seq_up_start_i || status_clear_i) |=> cnt_q == 3'h0)
		else $error("counter not cleared");
	c_retry: cover property (retry_q);
	c_frozen: cover property (st_q == ST_FROZEN);
	c_locked: cover property (st_q == ST_LOCKED);

endmodule : sfr_fault_response

/* File: sfr_far_model.sv */
// Far-side model: fault wire with pull-up, timing line, supply decay
`timescale 1ns/1ps
module sfr_far_model (
	// Clock
	input  wire logic       clk_i,
	// Pin drivers and test controls
	input  wire logic       oe_i,
	input  wire logic       ext_pull_i,
	input  wire logic       stop_i,
	input  wire logic       hold_i,
	input  wire logic [5:0] en_i,
	// Wire levels
	output logic            fault_line_o,
	output logic            timing_o,
	output logic [5:0]      discharged_o
);
	logic [5:0] d1_q = 6'h00;
	logic [5:0] d2_q = 6'h00;
	logic [1:0] div_q = 2'h0;
	logic       tog_q = 1'b0;
	// Pull-up holds the wire high unless some party sinks it
	assign fault_line_o = ~(oe_i | ext_pull_i);
	assign timing_o = tog_q;
	// Supplies decay two cycles after enable drops; hold keeps them up
	always @(posedge clk_i) begin
		d1_q <= ~en_i;
		d2_q <= d1_q;
		div_q <= div_q + 2'h1;
		if (!stop_i && div_q == 2'h3) tog_q <= ~tog_q; // Stops on demand
	end
	assign discharged_o = hold_i ? 6'h00 : (d2_q & ~en_i);
endmodule : sfr_far_model

/* File: sfr_fault_response_test.sv */
// Self-checking bench for the supply fault response block
`timescale 1ns/1ps
module sfr_fault_response_test;
	import sfr_pkg::*;
	localparam int DCYC = int'(DLY_US_1 * CLK_MHZ / 10000);
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	sfr_wr_s     reg_wr = '0;
	sfr_faults_s flt = '0;
	logic        clr = 1'b0, start = 1'b0, pull = 1'b0;
	logic        hold = 1'b0, tstop = 1'b0;
	logic [5:0]  want = 6'h3f;
	logic [15:0] rd;
	logic        retry, halt, line, line_o, oe, tline;
	logic [5:0]  dis, en;
	int          err_count = 0;
	int          n_tests = 0;
	// Clock at 200 MHz
	always #2.5 clk_i = ~clk_i;
	sfr_fault_response #(.DLY_SCALE_DIV(10000)) sfr_fault_response_i (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr),
		.status_clear_i(clr), .policy_rd_o(rd), .fault_i(flt),
		.seq_up_start_i(start), .seq_enable_i(1'b1), .seq_en_i(want),
		.discharged_i(dis), .retry_start_o(retry), .seq_halt_o(halt),
		.fault_line_i(line), .fault_line_o(line_o), .fault_line_oe_o(oe),
		.shared_timing_line_i(tline), .supply_enable_out_o(en));
	sfr_far_model sfr_far_model_i (
		.clk_i(clk_i), .oe_i(oe), .ext_pull_i(pull), .stop_i(tstop),
		.hold_i(hold), .en_i(en), .fault_line_o(line), .timing_o(tline),
		.discharged_o(dis));
	task automatic stop_test;
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	// One-cycle write strobe; the word shows one cycle later
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		@(posedge clk_i) reg_wr <= '{1'b1, cmd, d};
		@(posedge clk_i) reg_wr.wr <= 1'b0;
		#1;
	endtask : wr
	// Pulse: 0 start, 1 clear, 2 sequence fault, 3 external pull
	task automatic fire(input int k);
		@(posedge clk_i);
		case (k)
			0: start <= 1'b1;
			1: clr <= 1'b1;
			2: flt.seq <= 1'b1;
			default: pull <= 1'b1;
		endcase
		@(posedge clk_i) {start, clr, flt, pull} <= '0;
		#1;
	endtask : fire
	// Bounded wait for a retry pulse
	task automatic waitr(input int lim);
		int c;
		c = 0;
		while (retry !== 1'b1 && c < lim) begin
			step(1);
			c++;
		end
	endtask : waitr
	// Watchdog sized well past the longest scenario
	initial begin
		#400000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		step(2);
		chk(rd, 16'h0408);
		wr(8'h23, 16'hffff);
		chk(rd, 16'h07ff);
		wr(8'h24, 16'h0000);
		chk(rd, 16'h07ff);
		wr(8'h23, 16'h0009);
		fire(2);
		chk(oe, 1'b1);
		chk(line_o, 1'b0);
		chk(en, 6'h00);
		waitr(100);
		chk(retry, 1'b1);
		step(1);
		chk(rd[13:11], 3'h1);
		fire(2);
		waitr(200);
		chk(retry, 1'b0);
		chk(en, 6'h00);
		fire(0);
		chk(rd[13:11], 3'h0);
		chk(en, 6'h3f);
		fire(2);
		waitr(100);
		step(1);
		fire(1);
		chk(rd[13:11], 3'h0);
		// Delay-gated retry with supplies held charged
		hold <= 1'b1;
		wr(8'h23, 16'h0037);
		fire(2);
		waitr(DCYC - 100);
		chk(retry, 1'b0);
		waitr(300);
		chk(retry, 1'b1);
		wr(8'h23, 16'h003f);
		fire(2);
		waitr(DCYC + 200);
		chk(retry, 1'b0);
		@(posedge clk_i) hold <= 1'b0;
		waitr(50);
		chk(retry, 1'b1);
		// Supplies now discharge at once, so only the delay holds it
		fire(2);
		waitr(100);
		chk(retry, 1'b0);
		waitr(DCYC);
		chk(retry, 1'b1);
		wr(8'h23, 16'h0000);
		fire(2);
		chk(oe, 1'b1);
		chk({halt, en}, 7'h3f);
		wr(8'h23, 16'h0108);
		@(posedge clk_i) want <= 6'h0f;
		fire(2);
		@(posedge clk_i) want <= 6'h3f;
		step(2);
		chk({halt, en}, 7'h4f);
		fire(0);
		wr(8'h23, 16'h0008);
		fire(3);
		step(4);
		chk(en, 6'h3f);
		wr(8'h23, 16'h0208);
		fire(3);
		step(4);
		chk(en, 6'h00);
		fire(0);
		@(posedge clk_i) tstop <= 1'b1;
		step(TIMING_LOSS_CYC + 100);
		chk({oe, en}, 7'h40);
		stop_test();
	end
endmodule : sfr_fault_response_test
